// file: clkdiv_pkg.sv
/*
  Constants, register map and state types for the channel output dividers.
  Assumes a single core clock domain; divider input clocks arrive as pins
  that are oversampled by that clock.
*/
`default_nettype none

package clkdiv_pkg;

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_REG = 11;

  localparam logic [9:0] PAIR2_CYCLE_COUNTS_OFF    = 10'h196;
  localparam logic [9:0] PAIR2_CONTROL_OFF         = 10'h197;
  localparam logic [9:0] PAIR2_ROUTING_DUTY_OFF    = 10'h198;
  localparam logic [9:0] CHAN3_STAGE1_CYCLES_OFF   = 10'h199;
  localparam logic [9:0] CHAN3_PHASE_OFFSETS_OFF   = 10'h19A;
  localparam logic [9:0] CHAN3_STAGE2_CYCLES_OFF   = 10'h19B;
  localparam logic [9:0] CHAN3_CONTROL_OFF         = 10'h19C;
  localparam logic [9:0] CHAN3_DUTY_CORRECTION_OFF = 10'h19D;
  localparam logic [9:0] CHAN4_STAGE1_CYCLES_OFF   = 10'h19E;
  localparam logic [9:0] CHAN4_PHASE_OFFSETS_OFF   = 10'h19F;
  localparam logic [9:0] CHAN4_STAGE2_CYCLES_OFF   = 10'h1A0;
  localparam logic [9:0] DIVIDER_STATUS_OFF        = 10'h1A8;

  // Register indices: the map is contiguous from the first offset
  localparam logic [9:0] REG_BASE = PAIR2_CYCLE_COUNTS_OFF;
  localparam int IX_P2_CYC  = 0;
  localparam int IX_P2_CTL  = 1;
  localparam int IX_P2_RTE  = 2;
  localparam int IX_C3_CYC1 = 3;
  localparam int IX_C3_PH   = 4;
  localparam int IX_C3_CYC2 = 5;
  localparam int IX_C3_CTL  = 6;
  localparam int IX_C3_DCC  = 7;
  localparam int IX_C4_CYC1 = 8;
  localparam int IX_C4_PH   = 9;
  localparam int IX_C4_CYC2 = 10;

  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable bits per register, index 0 in the low byte
  localparam logic [NUM_REG-1:0][7:0] REG_WMASK =
    {8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
     8'h03, 8'hFF, 8'hFF};

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int P2_BYPASS_BIT = 7;
  localparam int P2_NOSYNC_BIT = 6;
  localparam int P2_FORCE_BIT  = 5;
  localparam int P2_START_BIT  = 4;
  localparam int P2_DIRECT_BIT = 1;
  localparam int DCC_OFF_BIT   = 0;
  localparam int CH_BYP2_BIT   = 5;
  localparam int CH_BYP1_BIT   = 4;
  localparam int CH_NOSYNC_BIT = 3;
  localparam int CH_FORCE_BIT  = 2;
  localparam int CH_START2_BIT = 1;
  localparam int CH_START1_BIT = 0;

  // Clock input selection codes
  localparam logic [1:0] SEL_EXT_CLK = 2'b00;
  localparam logic [1:0] SEL_VCO_CLK = 2'b10;

  // ------------------------------------------------------------------
  // Dividers and pins
  // ------------------------------------------------------------------
  localparam int NUM_DIV = 5;
  localparam int DV_P2   = 0;
  localparam int DV_C3A  = 1;
  localparam int DV_C3B  = 2;
  localparam int DV_C4A  = 3;
  localparam int DV_C4B  = 4;

  localparam int NUM_PIN = 4;
  localparam int PIN_DIV = 0;
  localparam int PIN_VCO = 1;
  localparam int PIN_EXT = 2;
  localparam int PIN_SYNC_B = 3;
  localparam logic [NUM_PIN-1:0] PIN_RESET = 4'h8;

  typedef struct packed {
    logic       level;
    logic       prev_in;
    logic       waiting;
    logic [3:0] cnt;
  } div_s;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] phase;
    logic       start_high;
    logic       bypass;
    logic       sync_en;
    logic       dcc_en;
  } div_cfg_s;

  typedef struct packed {
    logic [NUM_PIN-1:0] s1;
    logic [NUM_PIN-1:0] s2;
    logic [NUM_PIN-1:0] s3;
    logic [NUM_PIN-1:0] filt;
  } pin_sync_s;

endpackage : clkdiv_pkg

`default_nettype wire

// file: channel_output_dividers.sv
/*
  Third differential-pair divider and the two cascaded LVDS/CMOS channel
  dividers, with their register file.
  Assumes the divider input clocks and the sync pin are far slower than
  CORE_CLK (at least three core cycles per input level) so that the
  oversampled edges are seen; the clock input selection comes from logic
  on CORE_CLK.
*/
//
// What this block does
// - Pair divider high count in low nibble.
// - Pair divider low count sets low time.
// - Pair bypass bit passes input clock through.
// - Pair nosync bit ignores chip sync.
// - Pair force bit sets static level, needs nosync.
// - Pair start-high bit; low nibble phase offset.
// - Direct bit clear drives pair from divider.
// - Direct set, select 10b routes VCO.
// - Direct set, select 00b routes external clock.
// - Duty correction bit clear enables correction.
// - Channel 3 stage 1 low/high nibbles.
// - Channel 3 stage 2 low/high nibbles.
// - Phase register: upper stage 2, lower stage 1.
// - Channel 3 stage bypass bits 5 and 4.
// - Channel 3 nosync bit ignores chip sync.
// - Channel 3 force bit, needs nosync.
// - Channel 3 start levels bits 1 and 0.
// - Channel 4 stage 1 low/high nibbles.
// - Channel 4 stage 2 low/high nibbles.
`timescale 1ns/10ps
`default_nettype none

module channel_output_dividers
  import clkdiv_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  // Register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  // Clock sources and chip sync
  input  wire logic              DIV_CLK_IN,
  input  wire logic              VCO_CLK_IN,
  input  wire logic              EXT_CLK_IN,
  input  wire logic              SYNC_B,
  input  wire logic [1:0]        CLK_INPUT_SEL,
  // Clock outputs
  output logic                   PAIR2_OUTPUT_A,
  output logic                   PAIR2_OUTPUT_B,
  output logic                   CHAN3_OUT,
  output logic                   CHAN4_OUT
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    pin_sync_s                     pins;
    logic [NUM_REG-1:0][7:0]       regs;
    div_s [NUM_DIV-1:0]            div;
    logic                          pair2_ff;
    logic                          chan3_ff;
    logic                          chan4_ff;
    logic [DATA_W-1:0]             rdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // ------------------------------------------------------------------
  // Divider helpers
  // ------------------------------------------------------------------
  // Count fields hold cycles minus one, so a field of 0 is one cycle.
  function automatic div_s div_step(input div_s s, input div_cfg_s c,
                                    input logic in_lvl, input logic hold);
    div_s       n;
    logic       tick;
    logic [4:0] total;
    logic [4:0] half;
    logic [3:0] hi_eff;
    logic [3:0] lo_eff;
    logic [3:0] limit;
    n      = s;
    tick   = in_lvl & ~s.prev_in;
    total  = 5'(c.hi) + 5'(c.lo) + 5'h02;
    half   = total >> 1;
    hi_eff = c.hi;
    lo_eff = c.lo;
    // Balances high and low time over the same period
    if (c.dcc_en) begin
      hi_eff = 4'(half - 5'h01);
      lo_eff = 4'(total - half - 5'h01);
    end
    limit = s.level ? hi_eff : lo_eff;
    n.prev_in = in_lvl;
    if (hold && c.sync_en) begin
      n.level   = c.start_high;
      n.cnt     = c.phase;
      n.waiting = (c.phase != 4'h0);
    end else if (tick) begin
      if (s.waiting) begin
        if (s.cnt == 4'h1) begin
          n.waiting = 1'b0;
          n.cnt     = 4'h0;
        end else begin
          n.cnt = s.cnt - 4'h1;
        end
      end else if (s.cnt == limit) begin
        n.level = ~s.level;
        n.cnt   = 4'h0;
      end else begin
        n.cnt = s.cnt + 4'h1;
      end
    end
    return n;
  endfunction : div_step

  // A bypassed stage passes its input level straight out
  function automatic logic div_out(input div_s s, input div_cfg_s c,
                                   input logic in_lvl);
    return c.bypass ? in_lvl : s.level;
  endfunction : div_out

  // ------------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------------
  div_cfg_s [NUM_DIV-1:0] cfg;
  logic     [7:0]         p2_ctl;
  logic     [7:0]         c3_ctl;

  assign p2_ctl = st_ff.regs[IX_P2_CTL];
  assign c3_ctl = st_ff.regs[IX_C3_CTL];

  always_comb begin
    cfg = '0;
    cfg[DV_P2].hi         = st_ff.regs[IX_P2_CYC][3:0];
    cfg[DV_P2].lo         = st_ff.regs[IX_P2_CYC][7:4];
    cfg[DV_P2].phase      = p2_ctl[3:0];
    cfg[DV_P2].start_high = p2_ctl[P2_START_BIT];
    cfg[DV_P2].bypass     = p2_ctl[P2_BYPASS_BIT];
    cfg[DV_P2].sync_en    = ~p2_ctl[P2_NOSYNC_BIT];
    cfg[DV_P2].dcc_en     = ~st_ff.regs[IX_P2_RTE][DCC_OFF_BIT];

    cfg[DV_C3A].hi         = st_ff.regs[IX_C3_CYC1][3:0];
    cfg[DV_C3A].lo         = st_ff.regs[IX_C3_CYC1][7:4];
    cfg[DV_C3A].phase      = st_ff.regs[IX_C3_PH][3:0];
    cfg[DV_C3A].start_high = c3_ctl[CH_START1_BIT];
    cfg[DV_C3A].bypass     = c3_ctl[CH_BYP1_BIT];
    cfg[DV_C3A].sync_en    = ~c3_ctl[CH_NOSYNC_BIT];
    cfg[DV_C3A].dcc_en     = ~st_ff.regs[IX_C3_DCC][DCC_OFF_BIT];

    cfg[DV_C3B].hi         = st_ff.regs[IX_C3_CYC2][3:0];
    cfg[DV_C3B].lo         = st_ff.regs[IX_C3_CYC2][7:4];
    cfg[DV_C3B].phase      = st_ff.regs[IX_C3_PH][7:4];
    cfg[DV_C3B].start_high = c3_ctl[CH_START2_BIT];
    cfg[DV_C3B].bypass     = c3_ctl[CH_BYP2_BIT];
    cfg[DV_C3B].sync_en    = ~c3_ctl[CH_NOSYNC_BIT];
    cfg[DV_C3B].dcc_en     = ~st_ff.regs[IX_C3_DCC][DCC_OFF_BIT];

    // Channel 4 control sits outside this block: never bypassed,
    // always obeys sync, duty correction left off.
    cfg[DV_C4A].hi      = st_ff.regs[IX_C4_CYC1][3:0];
    cfg[DV_C4A].lo      = st_ff.regs[IX_C4_CYC1][7:4];
    cfg[DV_C4A].phase   = st_ff.regs[IX_C4_PH][3:0];
    cfg[DV_C4A].sync_en = 1'b1;

    cfg[DV_C4B].hi      = st_ff.regs[IX_C4_CYC2][3:0];
    cfg[DV_C4B].lo      = st_ff.regs[IX_C4_CYC2][7:4];
    cfg[DV_C4B].phase   = st_ff.regs[IX_C4_PH][7:4];
    cfg[DV_C4B].sync_en = 1'b1;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic [NUM_DIV-1:0] in_lvl;
  logic [NUM_DIV-1:0] dout;
  logic               sync_hold;
  logic               p2_path;
  logic [9:0]         reg_ix;
  logic               in_map;

  always_comb begin
    nxt_st = st_ff;

    // Three-stage pin sampling; a change is taken once the second and third stages agree
    nxt_st.pins.s1 = {SYNC_B, EXT_CLK_IN, VCO_CLK_IN, DIV_CLK_IN};
    nxt_st.pins.s2 = st_ff.pins.s1;
    nxt_st.pins.s3 = st_ff.pins.s2;
    for (int p = 0; p < NUM_PIN; p++) begin
      if (st_ff.pins.s2[p] == st_ff.pins.s3[p]) begin
        nxt_st.pins.filt[p] = st_ff.pins.s3[p];
      end
    end

    // Sync is held while the pin is low and released on its rise
    sync_hold = ~st_ff.pins.filt[PIN_SYNC_B];

    // First stages and the pair run from the divided input clock;
    // each second stage runs from its first stage output.
    in_lvl = '0;
    dout   = '0;
    in_lvl[DV_P2]  = st_ff.pins.filt[PIN_DIV];
    in_lvl[DV_C3A] = st_ff.pins.filt[PIN_DIV];
    in_lvl[DV_C4A] = st_ff.pins.filt[PIN_DIV];
    dout[DV_P2]  = div_out(st_ff.div[DV_P2], cfg[DV_P2], in_lvl[DV_P2]);
    dout[DV_C3A] = div_out(st_ff.div[DV_C3A], cfg[DV_C3A],
                           in_lvl[DV_C3A]);
    dout[DV_C4A] = div_out(st_ff.div[DV_C4A], cfg[DV_C4A],
                           in_lvl[DV_C4A]);
    in_lvl[DV_C3B] = dout[DV_C3A];
    in_lvl[DV_C4B] = dout[DV_C4A];
    dout[DV_C3B] = div_out(st_ff.div[DV_C3B], cfg[DV_C3B],
                           in_lvl[DV_C3B]);
    dout[DV_C4B] = div_out(st_ff.div[DV_C4B], cfg[DV_C4B],
                           in_lvl[DV_C4B]);

    for (int d = 0; d < NUM_DIV; d++) begin
      nxt_st.div[d] = div_step(st_ff.div[d], cfg[d], in_lvl[d],
                               sync_hold);
    end

    // Pair output: forced level only counts with nosync set
    p2_path = dout[DV_P2];
    if (p2_ctl[P2_NOSYNC_BIT]) begin
      p2_path = p2_ctl[P2_FORCE_BIT];
    end
    nxt_st.pair2_ff = p2_path;
    if (st_ff.regs[IX_P2_RTE][P2_DIRECT_BIT]) begin
      case (CLK_INPUT_SEL)
        SEL_VCO_CLK: nxt_st.pair2_ff = st_ff.pins.filt[PIN_VCO];
        SEL_EXT_CLK: nxt_st.pair2_ff = st_ff.pins.filt[PIN_EXT];
        default:     nxt_st.pair2_ff = p2_path;
      endcase
    end

    nxt_st.chan3_ff = dout[DV_C3B];
    if (c3_ctl[CH_NOSYNC_BIT]) begin
      nxt_st.chan3_ff = c3_ctl[CH_FORCE_BIT];
    end
    nxt_st.chan4_ff = dout[DV_C4B];

    // Register port: write in place, read data the next cycle only
    reg_ix = REG_ADDR - REG_BASE;
    in_map = (REG_ADDR >= REG_BASE) && (reg_ix < 10'(NUM_REG));
    if (REG_WR && in_map) begin
      nxt_st.regs[reg_ix[3:0]] = REG_WDATA & REG_WMASK[reg_ix[3:0]];
    end
    nxt_st.rdata = '0;
    if (REG_RD) begin
      if (in_map) begin
        nxt_st.rdata = st_ff.regs[reg_ix[3:0]];
      end else if (REG_ADDR == DIVIDER_STATUS_OFF) begin
        nxt_st.rdata = {3'h0, st_ff.pins.filt[PIN_SYNC_B],
                        st_ff.chan4_ff, st_ff.chan3_ff, 1'b0,
                        st_ff.pair2_ff};
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff           <= '0;
      st_ff.pins.s1   <= PIN_RESET;
      st_ff.pins.s2   <= PIN_RESET;
      st_ff.pins.s3   <= PIN_RESET;
      st_ff.pins.filt <= PIN_RESET;
      for (int r = 0; r < NUM_REG; r++) begin
        st_ff.regs[r] <= REG_RESET;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Complementary pair legs come from the same flop
  assign PAIR2_OUTPUT_A = st_ff.pair2_ff;
  assign PAIR2_OUTPUT_B = ~st_ff.pair2_ff;
  assign CHAN3_OUT      = st_ff.chan3_ff;
  assign CHAN4_OUT      = st_ff.chan4_ff;
  assign REG_RDATA      = st_ff.rdata;

endmodule : channel_output_dividers

`default_nettype wire

// file: channel_dividers_props.sv
/*
  Port-level checks for the channel output dividers.
  Assumes pair control and routing change only through REG_WR.
*/
`timescale 1ns/10ps
`default_nettype none

module channel_dividers_props
  import clkdiv_pkg::*;
(
  // Clock, reset and register port
  input wire logic              CORE_CLK,
  input wire logic              RST_B,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // Sources and pair outputs
  input wire logic              VCO_CLK_IN,
  input wire logic              SYNC_B,
  input wire logic [1:0]        CLK_INPUT_SEL,
  input wire logic              PAIR2_OUTPUT_A,
  input wire logic              PAIR2_OUTPUT_B
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  // ------------------------------------------------------------
  // Shadows and settle counters
  // ------------------------------------------------------------
  logic [7:0] p2ctl;
  logic [1:0] p2rte;
  logic [1:0] sel_q;
  logic [3:0] quiet;
  logic [3:0] slow;

  // Checks wait for settling: samplers add a few cycles of latency
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      p2ctl <= 8'h00;
      p2rte <= 2'h0;
      sel_q <= 2'h0;
      quiet <= 4'h0;
      slow  <= 4'h0;
    end else begin
      if (REG_WR && REG_ADDR == 10'h197) p2ctl <= REG_WDATA;
      if (REG_WR && REG_ADDR == 10'h198) p2rte <= REG_WDATA[1:0];
      sel_q <= CLK_INPUT_SEL;
      quiet <= (REG_WR || CLK_INPUT_SEL != sel_q) ? 4'h0 :
               (quiet == 4'hF ? quiet : quiet + 4'h1);
      slow  <= SYNC_B ? 4'h0 : (slow == 4'hF ? slow : slow + 4'h1);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data not zero outside read slot");
  a_pair_inverse: assert property (PAIR2_OUTPUT_B == ~PAIR2_OUTPUT_A)
    else $error("pair outputs not complementary");
  a_write_readback: assert property (REG_WR && REG_ADDR == 10'h199 ##1
      REG_RD && REG_ADDR == 10'h199 |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("read after write mismatch");
  a_unmapped_zero: assert property (REG_RD && (REG_ADDR < 10'h196 ||
      (REG_ADDR > 10'h1A0 && REG_ADDR != 10'h1A8)) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_route_reserved: assert property (REG_RD && REG_ADDR == 10'h198
      |=> REG_RDATA[7:2] == 6'h00)
    else $error("reserved routing bits not zero");
  a_ctl_reserved: assert property (REG_RD && REG_ADDR == 10'h19C
      |=> REG_RDATA[7:6] == 2'h0)
    else $error("reserved control bits not zero");
  a_sync_hold: assert property (slow == 4'hF && quiet == 4'hF &&
      p2ctl[7:6] == 2'b00 && !p2rte[1] |-> PAIR2_OUTPUT_A == p2ctl[4])
    else $error("pair not held at start level");
  a_force_level: assert property (quiet == 4'hF &&
      p2ctl[7:6] == 2'b01 && !p2rte[1] |-> PAIR2_OUTPUT_A == p2ctl[5])
    else $error("pair not at forced level");
  a_direct_vco: assert property (quiet == 4'hF && p2rte[1] &&
      CLK_INPUT_SEL == 2'b10 && $rose(VCO_CLK_IN)
      |-> ##[2:8] $rose(PAIR2_OUTPUT_A))
    else $error("vco edge not routed to pair");

  c_direct_vco: cover property (p2rte[1] && $rose(PAIR2_OUTPUT_A));
  c_forced_high: cover property (p2ctl[6:5] == 2'b11 && PAIR2_OUTPUT_A);
  c_sync_held: cover property (slow == 4'hF && PAIR2_OUTPUT_A);

endmodule : channel_dividers_props

bind channel_output_dividers channel_dividers_props channel_dividers_props_inst
(
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .VCO_CLK_IN(VCO_CLK_IN), .SYNC_B(SYNC_B),
  .CLK_INPUT_SEL(CLK_INPUT_SEL), .PAIR2_OUTPUT_A(PAIR2_OUTPUT_A),
  .PAIR2_OUTPUT_B(PAIR2_OUTPUT_B)
);

`default_nettype wire

// file: testbench.sv
/*
  Self-checking bench for the channel output dividers.
  Assumes source clocks made here from CORE_CLK, 8, 6 and 10 cycles long.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import clkdiv_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic              CORE_CLK, RST_B, REG_WR, REG_RD, SYNC_B;
  logic              DIV_CLK_IN, VCO_CLK_IN, EXT_CLK_IN;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
  logic [1:0]        CLK_INPUT_SEL;
  logic              PAIR2_OUTPUT_A, PAIR2_OUTPUT_B, CHAN3_OUT, CHAN4_OUT;
  int                fails, comparisons, tick, t0, t1;
  logic [7:0]        wmask [11] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF,
                                    8'hFF, 8'h3F, 8'h01, 8'hFF, 8'hFF, 8'hFF};

  channel_output_dividers channel_output_dividers_inst (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .DIV_CLK_IN(DIV_CLK_IN),
    .VCO_CLK_IN(VCO_CLK_IN), .EXT_CLK_IN(EXT_CLK_IN), .SYNC_B(SYNC_B),
    .CLK_INPUT_SEL(CLK_INPUT_SEL), .PAIR2_OUTPUT_A(PAIR2_OUTPUT_A),
    .PAIR2_OUTPUT_B(PAIR2_OUTPUT_B), .CHAN3_OUT(CHAN3_OUT),
    .CHAN4_OUT(CHAN4_OUT)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // Every level lasts at least three core cycles so no edge is lost
  always @(posedge CORE_CLK) begin
    tick <= tick + 1;
    DIV_CLK_IN <= (tick % 8) < 4;
    VCO_CLK_IN <= (tick % 6) < 3;
    EXT_CLK_IN <= (tick % 10) < 5;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  function automatic logic pick(input int which);
    case (which)
      0: return PAIR2_OUTPUT_A;
      1: return CHAN3_OUT;
      2: return CHAN4_OUT;
      default: return PAIR2_OUTPUT_B;
    endcase
  endfunction : pick

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  // Optional write, then a read of the same place in the next cycle
  task automatic wr_rd(input logic [9:0] a, input logic w,
                       input logic [7:0] d, exp);
    if (w) begin
      @(posedge CORE_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
    end
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 chk("read data", {8'h00, exp}, {8'h00, REG_RDATA});
  endtask : wr_rd

  // High and low time, in core cycles, of one full output period
  task automatic measure(input string what, input int which,
                         input logic [15:0] ehi, elo);
    int   n, hi, lo;
    logic prev;
    prev = 1'b1;
    n = 0;
    hi = 0;
    lo = 0;
    repeat (120) @(posedge CORE_CLK);
    while (!(pick(which) && !prev)) begin
      prev = pick(which);
      @(posedge CORE_CLK);
      #1 n++;
      if (n > 400) begin
        fails++;
        tally_and_finish();
      end
    end
    while (pick(which) === 1'b1 && hi < 400) begin
      @(posedge CORE_CLK);
      #1 hi++;
    end
    while (pick(which) === 1'b0 && lo < 400) begin
      @(posedge CORE_CLK);
      #1 lo++;
    end
    chk(what, ehi, hi[15:0]);
    chk(what, elo, lo[15:0]);
  endtask : measure

  task automatic hold(input string what, input int which, input logic exp);
    repeat (4) begin
      repeat (20) @(posedge CORE_CLK);
      #1 chk(what, {15'h0, exp}, {15'h0, pick(which)});
    end
  endtask : hold

  // Release sync aligned to the divider clock, time the first rise
  task automatic sync_rise(input logic [7:0] ctl, output int t);
    wr(10'h197, ctl);
    SYNC_B <= 1'b0;
    repeat (40) @(posedge CORE_CLK);
    while (tick % 8 != 0) @(posedge CORE_CLK);
    SYNC_B <= 1'b1;
    t = 0;
    while (PAIR2_OUTPUT_A !== 1'b1 && t < 400) begin
      @(posedge CORE_CLK);
      #1 t++;
    end
    if (t >= 400) begin
      fails++;
      tally_and_finish();
    end
  endtask : sync_rise

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    RST_B = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = '0;
    REG_WDATA = '0;
    SYNC_B = 1'b1;
    CLK_INPUT_SEL = 2'b01;
    tick = 0;
    DIV_CLK_IN = 1'b0;
    VCO_CLK_IN = 1'b0;
    EXT_CLK_IN = 1'b0;
    repeat (3) @(posedge CORE_CLK);
    #1 chk("reset outputs", 16'h0004, {4'h0, REG_RDATA, PAIR2_OUTPUT_A,
           PAIR2_OUTPUT_B, CHAN3_OUT, CHAN4_OUT});
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 11; i++) wr_rd(10'h196 + 10'(i), 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 11; i++) wr_rd(10'h196 + 10'(i), 1'b1, 8'hFF, wmask[i]);
    wr_rd(10'h195, 1'b1, 8'hFF, 8'h00);
    wr_rd(10'h1A5, 1'b1, 8'hFF, 8'h00);
    for (int i = 0; i < 11; i++) wr(10'h196 + 10'(i), 8'h00);
    wr(10'h196, 8'h02);
    wr(10'h198, 8'h01);
    measure("pair period", 0, 16'd24, 16'd8);
    wr(10'h198, 8'h00);
    measure("pair corrected", 0, 16'd16, 16'd16);
    wr(10'h198, 8'h01);
    wr(10'h197, 8'h80);
    measure("pair bypass", 0, 16'd4, 16'd4);
    wr(10'h197, 8'h00);
    wr(10'h198, 8'h03);
    CLK_INPUT_SEL <= 2'b10;
    measure("direct vco", 0, 16'd3, 16'd3);
    CLK_INPUT_SEL <= 2'b00;
    measure("direct ext", 0, 16'd5, 16'd5);
    CLK_INPUT_SEL <= 2'b01;
    measure("direct none", 0, 16'd24, 16'd8);
    wr(10'h198, 8'h01);
    wr(10'h197, 8'h60);
    hold("pair forced", 0, 1'b1);
    hold("pair inverse", 3, 1'b0);
    wr(10'h197, 8'h40);
    hold("pair forced low", 0, 1'b0);
    wr(10'h197, 8'h00);
    wr(10'h19D, 8'h01);
    wr(10'h199, 8'h01);
    wr(10'h19B, 8'h20);
    measure("chan3 cascade", 1, 16'd24, 16'd72);
    wr(10'h19D, 8'h00);
    measure("chan3 corrected", 1, 16'd48, 16'd48);
    wr(10'h19D, 8'h01);
    wr(10'h19C, 8'h10);
    measure("chan3 bypass one", 1, 16'd8, 16'd24);
    wr(10'h19C, 8'h30);
    measure("chan3 bypass both", 1, 16'd4, 16'd4);
    wr(10'h19C, 8'h0C);
    hold("chan3 forced", 1, 1'b1);
    wr(10'h19C, 8'h00);
    wr(10'h19E, 8'h10);
    wr(10'h1A0, 8'h01);
    measure("chan4 cascade", 2, 16'd48, 16'd24);
    SYNC_B <= 1'b0;
    wr(10'h197, 8'h10);
    wr(10'h19C, 8'h02);
    hold("pair start high", 0, 1'b1);
    hold("chan3 start high", 1, 1'b1);
    wr(10'h197, 8'h00);
    wr(10'h19C, 8'h01);
    hold("pair start low", 0, 1'b0);
    hold("chan3 start low", 1, 1'b0);
    hold("chan4 held", 2, 1'b0);
    wr(10'h197, 8'h60);
    wr(10'h19C, 8'h0C);
    hold("pair ignores sync", 0, 1'b1);
    hold("chan3 ignores sync", 1, 1'b1);
    wr(10'h19C, 8'h00);
    sync_rise(8'h00, t0);
    sync_rise(8'h02, t1);
    chk("phase delay", 16'd16, 16'(t1 - t0));
    tally_and_finish();
  end

endmodule : testbench

`default_nettype wire
